// file: adc_consts.svh
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH
// Behaviour
// - async enable wins, else select bus or alternate
// - alternate source is four times bus clock
// - async oscillator runs only while syncing or converting on it
// - async oscillator keeps running in stop mode
// - source divided by 1, 2, 4 or 8
// - no hardware trigger, software or continuous only
// - one channel routed, chosen by control write bits 4:0
// - control write starts conversion unless channel all ones
// - 10-bit right-justified, 8-bit rounded into low
// - continuous mode restarts after every transfer
// - single mode powers down after completion
// - transfer into result registers sets complete flag
// - interrupt raised when flag sets with enable
// - in 10-bit mode, high read without low read blocks transfer
// - blocked transfer always starts another conversion
// - control, clock write, reset or non-async stop aborts
// - abort keeps last result, reset clears it
// - first short 10-bit conversion 21 ticks plus 3 bus clocks
`define OFF_SC 8'h00
`define OFF_CFG 8'h04
`define OFF_RES_HI 8'h08
`define OFF_RES_LO 8'h0C
`define SC_CONVERSION_COMPLETE 7
`define SC_IE 6
`define SC_CONT 5
`define CFG_SEL_BUS 0
`define CFG_ASYNC 1
`define CFG_TEN_BIT 2
`define CFG_LONG 3
`define CFG_DIV_LO 5
`define CH_IDLE 5'h1F
`define SYNC_BUS_CLOCKS 2'h3
`define TICKS_10 6'h13
`define TICKS_8 6'h10
`define TICKS_LONG 6'h14
`define TICKS_FIRST 6'h02
`define ALT_PER_BUS 5'h04
`endif

// file: adc_pkg.sv
package adc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SYNC = 3'b010,
        ST_CONV = 3'b100
    } state_e;

    typedef struct packed {
        state_e state;
        logic [4:0] ch;
        logic ie;
        logic cont;
        logic conversion_complete;
        logic irq;
        logic hi_read;
        logic sel_bus;
        logic async_en;
        logic ten_bit;
        logic long_smp;
        logic [1:0] div;
        logic [1:0] res_hi;
        logic [7:0] res_lo;
        logic first;
        logic [5:0] cnt;
        logic [1:0] sync_cnt;
        logic [3:0] acc;
        logic tick;
        logic power;
        logic osc_en;
        logic ac1;
        logic ac2;
        logic ac3;
        logic st1;
        logic st2;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ctl_s;
endpackage

// file: sar_adc_conversion_control.sv
`timescale 1ns/1ns
`include "adc_consts.svh"
module sar_adc_conversion_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic async_clk_in,
    input wire logic stop_mode,
    input wire logic [9:0] core_result,
    output logic [4:0] core_channel,
    output logic core_power,
    output logic core_clock_tick,
    output logic async_osc_enable,
    output logic irq
);
    import adc_pkg::*;

    ctl_s ctl_reg;
    ctl_s ctl_next;

    function automatic logic [5:0] conv_len(input logic ten, input logic lng, input logic fst);
        logic [5:0] n;
        n = ten ? `TICKS_10 : `TICKS_8;
        if (lng) n = n + `TICKS_LONG;
        if (fst) n = n + `TICKS_FIRST;
        return n - 6'h01;
    endfunction

    function automatic logic [7:0] round8(input logic [9:0] v);
        return (v[9:2] == 8'hFF) ? 8'hFF : v[9:2] + {7'h00, v[1]};
    endfunction

    logic setup;
    logic access_done;
    logic wr_sc;
    logic wr_cfg;
    logic rd_hi;
    logic rd_lo;
    logic async_edge;
    logic stop_abort;
    logic conv_end;
    logic blocked;
    logic [4:0] inc;
    logic [4:0] ratio;
    logic [4:0] sum;
    logic abort;

    assign setup = psel && !penable;
    assign access_done = psel && penable && ctl_reg.pready;
    assign wr_sc = access_done && pwrite && paddr == `OFF_SC;
    assign wr_cfg = access_done && pwrite && paddr == `OFF_CFG;
    assign rd_hi = access_done && !pwrite && paddr == `OFF_RES_HI;
    assign rd_lo = access_done && !pwrite && paddr == `OFF_RES_LO;
    assign async_edge = ctl_reg.ac2 && !ctl_reg.ac3;
    // stop without the async oscillator kills the conversion
    assign stop_abort = ctl_reg.st2 && !ctl_reg.async_en;
    assign conv_end = ctl_reg.state == ST_CONV && ctl_reg.tick && ctl_reg.cnt == 6'h00;
    assign blocked = ctl_reg.ten_bit && ctl_reg.hi_read;
    assign abort = wr_sc || wr_cfg || stop_abort;

    // source edges per bus clock
    always_comb begin
        if (ctl_reg.async_en) begin
            inc = {4'h0, async_edge};
        end else if (ctl_reg.sel_bus) begin
            inc = 5'h01;
        end else begin
            inc = `ALT_PER_BUS;
        end
        ratio = 5'h01 << ctl_reg.div;
        sum = {1'b0, ctl_reg.acc} + inc;
    end

    always_comb begin
        ctl_next = ctl_reg;
        ctl_next.ac1 = async_clk_in;
        ctl_next.ac2 = ctl_reg.ac1;
        ctl_next.ac3 = ctl_reg.ac2;
        ctl_next.st1 = stop_mode;
        ctl_next.st2 = ctl_reg.st1;
        ctl_next.pready = setup && !ctl_reg.pready;
        ctl_next.tick = 1'b0;
        if (setup) begin
            ctl_next.pslverr = 1'b0;
            ctl_next.prdata = 32'h0000_0000;
            case (paddr)
                `OFF_SC: ctl_next.prdata[7:0] =
                    {ctl_reg.conversion_complete, ctl_reg.ie, ctl_reg.cont, ctl_reg.ch};
                `OFF_CFG: ctl_next.prdata[6:0] = {ctl_reg.div, 1'b0, ctl_reg.long_smp,
                    ctl_reg.ten_bit, ctl_reg.async_en, ctl_reg.sel_bus};
                `OFF_RES_HI: ctl_next.prdata[1:0] = ctl_reg.res_hi;
                `OFF_RES_LO: ctl_next.prdata[7:0] = ctl_reg.res_lo;
                default: ctl_next.pslverr = 1'b1;
            endcase
        end
        if (rd_hi && ctl_reg.ten_bit) begin
            ctl_next.hi_read = 1'b1;
        end
        if (rd_lo) begin
            ctl_next.hi_read = 1'b0;
            ctl_next.conversion_complete = 1'b0;
            ctl_next.irq = 1'b0;
        end
        // converter clock divider, runs only outside ST_IDLE, during sync and conversion
        if (ctl_reg.state != ST_IDLE) begin
            if (sum >= ratio) begin
                ctl_next.tick = 1'b1;
                ctl_next.acc = 4'h0;
            end else begin
                ctl_next.acc = sum[3:0];
            end
        end
        case (ctl_reg.state)
            ST_IDLE: begin
            end
            ST_SYNC: begin
                ctl_next.sync_cnt = ctl_reg.sync_cnt - 2'h1;
                if (ctl_reg.sync_cnt == 2'h1) begin
                    ctl_next.state = ST_CONV;
                    ctl_next.acc = 4'h0;
                    // first conversion carries two extra ticks
                    ctl_next.cnt = conv_len(ctl_reg.ten_bit, ctl_reg.long_smp, 1'b1);
                    ctl_next.first = 1'b1;
                end
            end
            ST_CONV: begin
                if (ctl_reg.tick && ctl_reg.cnt != 6'h00) begin
                    ctl_next.cnt = ctl_reg.cnt - 6'h01;
                end
                // an abort in the same cycle drops the result
                if (conv_end && !abort) begin
                    ctl_next.cnt = conv_len(ctl_reg.ten_bit, ctl_reg.long_smp, 1'b0);
                    ctl_next.first = 1'b0;
                    if (blocked) begin
                        ctl_next.state = ST_CONV;
                    end else begin
                        if (ctl_reg.ten_bit) begin
                            ctl_next.res_hi = core_result[9:8];
                            ctl_next.res_lo = core_result[7:0];
                        end else begin
                            ctl_next.res_hi = 2'h0;
                            ctl_next.res_lo = round8(core_result);
                        end
                        ctl_next.conversion_complete = 1'b1;
                        if (ctl_reg.ie) begin
                            ctl_next.irq = 1'b1;
                        end
                        ctl_next.state = ctl_reg.cont ? ST_CONV : ST_IDLE;
                    end
                end
            end
            default: ctl_next.state = ST_IDLE;
        endcase
        // aborts leave the result registers untouched
        if (stop_abort || wr_cfg) begin
            ctl_next.state = ST_IDLE;
        end
        if (wr_cfg) begin
            ctl_next.sel_bus = pwdata[`CFG_SEL_BUS];
            ctl_next.async_en = pwdata[`CFG_ASYNC];
            ctl_next.ten_bit = pwdata[`CFG_TEN_BIT];
            ctl_next.long_smp = pwdata[`CFG_LONG];
            ctl_next.div = pwdata[`CFG_DIV_LO+:2];
        end
        // only software starts a conversion
        if (wr_sc) begin
            ctl_next.ch = pwdata[4:0];
            ctl_next.ie = pwdata[`SC_IE];
            ctl_next.cont = pwdata[`SC_CONT];
            ctl_next.conversion_complete = 1'b0;
            ctl_next.irq = 1'b0;
            if (pwdata[4:0] == `CH_IDLE) begin
                ctl_next.state = ST_IDLE;
            end else begin
                ctl_next.state = ST_SYNC;
                ctl_next.sync_cnt = `SYNC_BUS_CLOCKS;
            end
        end
        ctl_next.power = ctl_next.state != ST_IDLE;
        ctl_next.osc_en = ctl_next.power && ctl_next.async_en;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_reg <= '{state: ST_IDLE, ch: `CH_IDLE, div: 2'h0, res_hi: 2'h0,
                res_lo: 8'h00, cnt: 6'h00, sync_cnt: 2'h0, acc: 4'h0,
                prdata: 32'h0000_0000, default: 1'b0};
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    assign prdata = ctl_reg.prdata;
    assign pready = ctl_reg.pready;
    assign pslverr = ctl_reg.pslverr;
    assign core_channel = ctl_reg.ch;
    assign core_power = ctl_reg.power;
    assign core_clock_tick = ctl_reg.tick;
    assign async_osc_enable = ctl_reg.osc_en;
    assign irq = ctl_reg.irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence good_end;
        conv_end && !blocked && !wr_sc && !wr_cfg && !stop_abort && !rd_lo;
    endsequence

    sequence bad_end;
        conv_end && blocked && !wr_sc && !wr_cfg && !stop_abort && !rd_lo;
    endsequence

    conversion_complete_set_a: assert property (good_end |=> ctl_reg.conversion_complete)
        else $error("complete flag not set on transfer");
    irq_raise_a: assert property (good_end ##0 ctl_reg.ie |=> irq)
        else $error("interrupt missing on completion");
    irq_quiet_a: assert property (good_end ##0 !ctl_reg.ie && !irq |=> !irq)
        else $error("interrupt raised while disabled");
    block_keep_a: assert property (bad_end |=> $stable(ctl_reg.res_lo) &&
        ctl_reg.conversion_complete == $past(ctl_reg.conversion_complete))
        else $error("blocked transfer changed result");
    block_restart_a: assert property (bad_end |=> ctl_reg.state == ST_CONV)
        else $error("no restart after blocked transfer");
    single_off_a: assert property (good_end ##0 !ctl_reg.cont |=>
        ctl_reg.state == ST_IDLE ##0 !core_power)
        else $error("single conversion did not power down");
    cont_next_a: assert property (good_end ##0 ctl_reg.cont |=> ctl_reg.state == ST_CONV)
        else $error("continuous mode did not restart");
    idle_write_a: assert property (wr_sc && pwdata[4:0] == `CH_IDLE |=>
        ctl_reg.state == ST_IDLE)
        else $error("all-ones channel started conversion");
    start_write_a: assert property (wr_sc && pwdata[4:0] != `CH_IDLE |=>
        ctl_reg.state == ST_SYNC ##3 ctl_reg.state == ST_CONV)
        else $error("control write did not start conversion");
    cfg_abort_a: assert property (wr_cfg && !wr_sc |=> !core_power &&
        $stable(ctl_reg.res_lo))
        else $error("clock write did not abort");
    osc_gate_a: assert property (async_osc_enable |-> core_power && ctl_reg.async_en)
        else $error("async oscillator on outside conversion");
    round_a: assert property (good_end ##0 !ctl_reg.ten_bit |=>
        ctl_reg.res_lo == round8($past(core_result)) && ctl_reg.res_hi == 2'h0)
        else $error("8-bit result not rounded");
    bus_tick_a: assert property (ctl_reg.state == ST_CONV && ctl_reg.sel_bus &&
        !ctl_reg.async_en && ctl_reg.div == 2'h0 |=> core_clock_tick)
        else $error("bus source divide-by-one missed tick");

    sequence first_conv;
        ctl_reg.state == ST_CONV && ctl_reg.first && ctl_reg.ten_bit && !ctl_reg.long_smp;
    endsequence

    sequence later_conv;
        ctl_reg.state == ST_CONV && !ctl_reg.first && ctl_reg.ten_bit && !ctl_reg.long_smp;
    endsequence

    first_len_a: assert property (first_conv |-> ctl_reg.cnt <= 6'h14)
        else $error("first conversion longer than allowed");
    later_len_a: assert property (later_conv |-> ctl_reg.cnt <= 6'h12)
        else $error("later conversion longer than allowed");
    block_reload_a: assert property (bad_end ##0 !ctl_reg.long_smp |=>
        ctl_reg.cnt == 6'h12)
        else $error("blocked restart has wrong length");
    ten_res_a: assert property (good_end ##0 ctl_reg.ten_bit |=>
        ctl_reg.res_lo == $past(core_result[7:0]) && ctl_reg.res_hi == $past(core_result[9:8]))
        else $error("10-bit result not placed right-justified");
    chan_follow_a: assert property (wr_sc |=> core_channel == $past(pwdata[4:0]))
        else $error("routed channel differs from written channel");
    idle_hold_a: assert property (ctl_reg.state == ST_IDLE && !wr_sc |=>
        ctl_reg.state == ST_IDLE)
        else $error("conversion started without a control write");
    start_power_a: assert property (wr_sc && pwdata[4:0] != `CH_IDLE |=>
        core_power && async_osc_enable == ctl_reg.async_en)
        else $error("converter not powered after start");
    alt_tick_a: assert property (ctl_reg.state != ST_IDLE && !ctl_reg.sel_bus &&
        !ctl_reg.async_en && ctl_reg.div != 2'h3 |=> core_clock_tick)
        else $error("alternate source missed tick");
    div8_gap_a: assert property (ctl_reg.state != ST_IDLE && ctl_reg.sel_bus &&
        !ctl_reg.async_en && ctl_reg.div == 2'h3 && ctl_reg.acc != 4'h7 |=> !core_clock_tick)
        else $error("divide-by-eight ticked early");
    async_wait_a: assert property (ctl_reg.async_en && !async_edge &&
        ctl_reg.acc == 4'h0 |=> !core_clock_tick)
        else $error("async source ticked without an edge");
    cont_power_a: assert property (good_end ##0 ctl_reg.cont |=> core_power)
        else $error("continuous mode powered down");
    single_osc_a: assert property (good_end ##0 !ctl_reg.cont |=> !async_osc_enable)
        else $error("async oscillator left on after single conversion");
    stop_abort_a: assert property (stop_abort && !wr_sc |=> !core_power &&
        $stable(ctl_reg.res_lo))
        else $error("stop did not abort cleanly");
    stop_keep_a: assert property (ctl_reg.st2 && ctl_reg.async_en &&
        ctl_reg.state == ST_CONV && !conv_end && !wr_sc && !wr_cfg |=> core_power)
        else $error("async conversion stopped in stop mode");
    block_mark_a: assert property (rd_hi && ctl_reg.ten_bit |=> ctl_reg.hi_read)
        else $error("high read not marked");
endmodule // sar_adc_conversion_control

// file: adc_core_model.sv
`timescale 1ns/1ns
module adc_core_model (
    input wire logic pclk,
    input wire logic core_power,
    input wire logic [4:0] core_channel,
    input wire logic async_osc_enable,
    output logic [9:0] core_result,
    output logic async_clk_in
);
    initial begin
        core_result = 10'h000;
        async_clk_in = 1'b0;
    end
    // result follows the routed channel only; unpowered core shows junk
    always @(posedge pclk) begin
        core_result <= core_power ? ({core_channel, core_channel} ^ 10'h2A5) : ~core_result;
    end
    // odd-ns edges keep this oscillator off the bus clock edges
    initial begin
        #1;
        forever begin
            #6;
            async_clk_in = async_osc_enable ? ~async_clk_in : 1'b0;
        end
    end
endmodule // adc_core_model

// file: tb.sv
`timescale 1ns/1ns
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stop_mode, irq;
    logic core_power, core_clock_tick, async_osc_enable, async_clk_in;
    logic [7:0] paddr, elo;
    logic [31:0] pwdata, prdata, rv;
    logic [9:0] core_result, er;
    logic [4:0] core_channel, ch;
    int fail_count, n_tests, seed, cyc, last_t, gap, nt, k, eg;
    sar_adc_conversion_control u_sar_adc_conversion_control (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .async_clk_in(async_clk_in),
        .stop_mode(stop_mode), .core_result(core_result), .core_channel(core_channel),
        .core_power(core_power), .core_clock_tick(core_clock_tick),
        .async_osc_enable(async_osc_enable), .irq(irq));
    adc_core_model u_adc_core_model (.pclk(pclk), .core_power(core_power),
        .core_channel(core_channel), .async_osc_enable(async_osc_enable),
        .core_result(core_result), .async_clk_in(async_clk_in));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // spacing and count of converter ticks while powered
    always @(posedge pclk) begin
        cyc++;
        if (core_clock_tick === 1'b1 && core_power === 1'b1) begin
            gap = cyc - last_t;
            last_t = cyc;
            nt++;
        end
    end
    function automatic logic [9:0] res(input logic [4:0] c);
        return {c, c} ^ 10'h2A5;
    endfunction
    function automatic logic [7:0] lo8(input logic [9:0] r);
        return (r[9:2] == 8'hFF) ? 8'hFF : r[9:2] + 8'(r[1]);
    endfunction
    task complete_run;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            fail_count++;
            complete_run();
        end
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask
    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h00000000);
    endtask
    task wait_flag;
        int i;
        for (i = 0; i < 400; i++) begin
            rd(8'h00);
            if (rv[7] === 1'b1) break;
        end
        if (i == 400) begin
            fail_count++;
            complete_run();
        end
    endtask
    task do_reset;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    initial begin
        seed = 32;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        stop_mode = 1'b0;
        presetn = 1'b0;
        do_reset();
        rd(8'h00);
        chk(rv, 32'h0000001F);
        rd(8'h0C);
        chk(rv, 32'h00000000);
        wr(8'h10, 8'h01);
        chk({31'h0, pslverr}, 32'h1);
        wr(8'h00, 8'h1F);
        repeat (50) @(posedge pclk);
        chk({31'h0, core_power}, 32'h0);
        $display("test idle done");
        for (k = 0; k < 16; k++) begin
            ch = 5'($unsigned($random(seed)) % 31);
            wr(8'h04, {1'b0, 2'(k >> 1), 1'b0, k[2], k[0], 1'b0, k[3]});
            eg = k[3] ? (1 << k[2:1]) : ((k[2:1] == 2'h3) ? 2 : 1);
            nt = 0;
            wr(8'h00, {1'b0, k[1], 1'b0, ch});
            chk({27'h0, core_channel}, {27'h0, ch});
            repeat (30) @(posedge pclk);
            chk(32'(gap), 32'(eg));
            wait_flag();
            chk({31'h0, irq}, {31'h0, k[1]});
            chk(32'(nt <= (k[0] ? 21 : 18) + (k[2] ? 20 : 0) + 3), 32'h1);
            chk({31'h0, core_power}, 32'h0);
            er = res(ch);
            elo = k[0] ? er[7:0] : lo8(er);
            rd(8'h08);
            chk(rv, k[0] ? {30'h0, er[9:8]} : 32'h0);
            rd(8'h0C);
            chk(rv, {24'h000000, elo});
            chk({31'h0, irq}, 32'h0);
        end
        $display("test modes done");
        wr(8'h04, 8'h05);
        wr(8'h00, 8'h03);
        rd(8'h08);
        repeat (200) @(posedge pclk);
        rd(8'h00);
        chk({31'h0, rv[7]}, 32'h0);
        chk({31'h0, core_power}, 32'h1);
        rd(8'h0C);
        chk(rv, {24'h000000, elo});
        wait_flag();
        rd(8'h0C);
        er = res(5'h03);
        chk(rv, {24'h000000, er[7:0]});
        $display("test blocking done");
        wr(8'h00, 8'h25);
        wait_flag();
        rd(8'h0C);
        wait_flag();
        chk({31'h0, core_power}, 32'h1);
        wr(8'h04, 8'h05);
        @(posedge pclk);
        chk({31'h0, core_power}, 32'h0);
        rd(8'h0C);
        er = res(5'h05);
        chk(rv, {24'h000000, er[7:0]});
        $display("test continuous done");
        wr(8'h00, 8'h06);
        repeat (10) @(posedge pclk);
        stop_mode <= 1'b1;
        repeat (6) @(posedge pclk);
        chk({31'h0, core_power}, 32'h0);
        stop_mode <= 1'b0;
        rd(8'h0C);
        chk(rv, {24'h000000, er[7:0]});
        wr(8'h04, 8'h06);
        wr(8'h00, 8'h07);
        repeat (5) @(posedge pclk);
        chk({31'h0, async_osc_enable}, 32'h1);
        stop_mode <= 1'b1;
        wait_flag();
        stop_mode <= 1'b0;
        chk({31'h0, async_osc_enable}, 32'h0);
        rd(8'h0C);
        er = res(5'h07);
        chk(rv, {24'h000000, er[7:0]});
        $display("test stop async done");
        do_reset();
        rd(8'h0C);
        chk(rv, 32'h00000000);
        $display("test reset done");
        complete_run();
    end
endmodule // tb
